// *** include/adc_chain_pkg.sv ***
// shared constants and types for the converter chain link
package adc_chain_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WORD_W = 32;
    localparam int CHAIN_LEN = 1;
    localparam int FIFO_DEPTH = 32;
    localparam int T_CONV_NS = 660;
    localparam int T_CONV_MAX_NS = 1000;
    localparam int T_ACQ_MIN_NS = 340;
    localparam int RESET_LOW_PULSE_MIN_NS = 500;
    localparam int APP_RESET_DELAY_NS = 1000;
    localparam int POR_RESET_DELAY_NS = 20000;
    localparam int SCLK_HALF_NS = 400;

    // least times round up, longest times round down, never below one cycle
    function automatic logic [15:0] cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 16'h0001 : 16'(c);
    endfunction : cyc_up

    function automatic logic [15:0] cyc_dn(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 16'h0001 : 16'(c);
    endfunction : cyc_dn

    localparam logic [15:0] CONV_CYC = cyc_up(T_CONV_NS);
    localparam logic [15:0] CONV_MAX_CYC = cyc_dn(T_CONV_MAX_NS);
    localparam logic [15:0] ACQ_MIN_CYC = cyc_up(T_ACQ_MIN_NS);
    localparam logic [15:0] RST_LOW_CYC = cyc_up(RESET_LOW_PULSE_MIN_NS);
    localparam logic [15:0] APP_RST_CYC = cyc_up(APP_RESET_DELAY_NS);
    localparam logic [15:0] POR_RST_CYC = cyc_up(POR_RESET_DELAY_NS);
    localparam logic [15:0] SCLK_HALF_CYC = cyc_up(SCLK_HALF_NS);
    localparam logic [5:0] FULL_FRAME = 6'h20;
    localparam logic [5:0] CNT_SAT = 6'h3F;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1F;
    localparam logic [15:0] FRAME_BITS = 16'(WORD_W * CHAIN_LEN);
    localparam logic [31:0] NOP_WORD = 32'h0000_0000;
    localparam logic [15:0] OUT_PAD = 16'h0000;

    typedef enum logic [1:0] {ST_RESET, ST_ACQ, ST_CONV} dev_state_t;
    typedef enum logic [2:0] {H_RST, H_BOOT, H_IDLE, H_FRAME, H_CLOSE, H_WAIT, H_ACQ} host_state_t;
endpackage : adc_chain_pkg

// *** include/adc_link_if.sv ***
// link between the host end and one converter end
`timescale 1ns/1ps
interface adc_link_if;
    logic convert_start_select;
    logic sclk;
    logic serial_in;
    logic reset_n;
    logic serial_out_primary;
    logic sdo_oe_n;
    logic ready_strobe;
    logic sdo_line;

    // released output reads as a weak high
    assign sdo_line = sdo_oe_n ? 1'b1 : serial_out_primary;

    modport dev (
        input convert_start_select,
        input sclk,
        input serial_in,
        input reset_n,
        output serial_out_primary,
        output sdo_oe_n,
        output ready_strobe
    );

    modport host (
        output convert_start_select,
        output sclk,
        output serial_in,
        output reset_n,
        input sdo_line,
        input ready_strobe
    );
endinterface : adc_link_if

// *** src/adc_dev_end.sv ***
// converter end: functional states and chained shift register
`timescale 1ns/1ps
// Operation
// - host needs only select, clock, data pins
// - host writes identical configuration to all devices
// - chain uses primary output, legacy protocol only
// - sample on select rise, frame on fall
// - launch edge drives shift register MSB out
// - capture edge shifts input into LSB
// - select rise decodes shift register contents
// - host gives 32 times N capture edges
// - longer frames must align each device's word
// - host holds reset low minimum pulse width
// - select bit picks application or power-on reset
// - application reset: defaults, ready low, output released
// - power-on reset needs settling delay after release
// - leave reset with select, clock low; ready rises
// - with reset high, select alone changes state
// - acquire after power-up, reset, each conversion
// - reset fall to reset; select rise converts
// - select ignored until conversion finishes
// - host spaces starts by conversion plus acquisition
// - thirty-two bit shift register moves both ways
// - select fall clears counter, loads output word
// - fewer than 32 clocks becomes no-operation
// - host waits ready rise or maximum conversion time
module adc_dev_end
    import adc_chain_pkg::*;
(
    // system
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // link
    adc_link_if.dev LINK,
    // converter core
    input wire logic [15:0] ANALOG_CODE_I,
    input wire logic RESET_FUNC_SEL_I,
    // command processor
    output logic [31:0] CMD_WORD_O,
    output logic CMD_VALID_O,
    output logic SHORT_FRAME_O,
    // status
    output logic [15:0] RESULT_O,
    output logic [1:0] STATE_O,
    output logic APP_RESET_O,
    output logic POR_O
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sclk_s;
        logic [1:0] sdi_s;
        logic [1:0] rstn_s;
        dev_state_t state;
        logic [15:0] timer;
        logic [5:0] clk_cnt;
        logic [31:0] shreg;
        logic [15:0] sample;
        logic [15:0] result;
        logic [31:0] cmd;
        logic cmd_valid;
        logic short_frame;
        logic sdo;
        logic sdo_oe_n;
        logic rdy;
        logic in_frame;
        logic app_rst;
    } dev_t;

    // power-up behaves as a power-on reset
    localparam dev_t DEV_INIT = '{
        state: ST_RESET,
        timer: POR_RST_CYC,
        sdo_oe_n: 1'b1,
        default: '0
    };

    dev_t r;
    dev_t n;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;

    // one edge test for the select and clock pins
    function automatic logic rose_at(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction : rose_at

    function automatic logic fell_at(input logic [2:0] s);
        return ~s[1] & s[2];
    endfunction : fell_at

    // reset delay and conversion share one down-counter shape
    function automatic logic timer_out(input logic [15:0] t);
        return t <= 16'h0001;
    endfunction : timer_out

    function automatic logic [15:0] timer_step(input logic [15:0] t);
        return t - 16'h0001;
    endfunction : timer_step

    // edges come from second and third stages only
    assign cs_rise = rose_at(r.cs_s);
    assign cs_fall = fell_at(r.cs_s);
    assign sclk_rise = rose_at(r.sclk_s);
    assign sclk_fall = fell_at(r.sclk_s);

    always_comb begin
        n = r;
        n.cs_s = {r.cs_s[1:0], LINK.convert_start_select};
        n.sclk_s = {r.sclk_s[1:0], LINK.sclk};
        n.sdi_s = {r.sdi_s[0], LINK.serial_in};
        n.rstn_s = {r.rstn_s[0], LINK.reset_n};
        n.cmd_valid = 1'b0;
        n.short_frame = 1'b0;
        if (!r.rstn_s[1]) begin
            // reset pin low wins over every state
            n.state = ST_RESET;
            n.app_rst = RESET_FUNC_SEL_I;
            n.timer = RESET_FUNC_SEL_I ? APP_RST_CYC : POR_RST_CYC;
            n.cmd = NOP_WORD;
            n.rdy = 1'b0;
            n.sdo_oe_n = 1'b1;
            n.in_frame = 1'b0;
            n.clk_cnt = '0;
        end else begin
            case (r.state)
                ST_RESET: begin
                    // delay runs only while select and clock stay low
                    if (!r.cs_s[1] && !r.sclk_s[1]) begin
                        if (timer_out(r.timer)) begin
                            n.state = ST_ACQ;
                            n.rdy = 1'b1;
                        end else begin
                            n.timer = timer_step(r.timer);
                        end
                    end
                end
                ST_ACQ: begin
                    if (cs_fall) begin
                        n.in_frame = 1'b1;
                        n.clk_cnt = '0;
                        n.shreg = {r.result, OUT_PAD};
                        n.sdo = r.result[15];
                        n.sdo_oe_n = 1'b0;
                        n.rdy = 1'b0;
                    end else if (cs_rise) begin
                        n.state = ST_CONV;
                        n.timer = CONV_CYC;
                        n.sample = ANALOG_CODE_I;
                        n.in_frame = 1'b0;
                        n.sdo_oe_n = 1'b1;
                        n.rdy = 1'b0;
                        n.cmd_valid = 1'b1;
                        // long frames keep the last 32 bits shifted in
                        if (r.in_frame && r.clk_cnt >= FULL_FRAME) begin
                            n.cmd = r.shreg;
                        end else begin
                            n.cmd = NOP_WORD;
                            n.short_frame = 1'b1;
                        end
                    end else if (r.in_frame) begin
                        if (sclk_rise) begin
                            n.shreg = {r.shreg[30:0], r.sdi_s[1]};
                            if (r.clk_cnt != CNT_SAT) begin
                                n.clk_cnt = r.clk_cnt + 6'h01;
                            end
                        end
                        if (sclk_fall) begin
                            n.sdo = r.shreg[31];
                        end
                    end
                end
                ST_CONV: begin
                    // select edges are dropped here on purpose
                    if (timer_out(r.timer)) begin
                        n.state = ST_ACQ;
                        n.rdy = 1'b1;
                        n.result = r.sample;
                    end else begin
                        n.timer = timer_step(r.timer);
                    end
                end
                default: begin
                    n.state = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= DEV_INIT;
        end else if (CE_I) begin
            r <= n;
        end
    end

    assign LINK.serial_out_primary = r.sdo;
    assign LINK.sdo_oe_n = r.sdo_oe_n;
    assign LINK.ready_strobe = r.rdy;
    assign CMD_WORD_O = r.cmd;
    assign CMD_VALID_O = r.cmd_valid;
    assign SHORT_FRAME_O = r.short_frame;
    assign RESULT_O = r.result;
    assign STATE_O = r.state;
    assign APP_RESET_O = (r.state == ST_RESET) & r.app_rst;
    assign POR_O = (r.state == ST_RESET) & ~r.app_rst;
endmodule : adc_dev_end

// *** src/adc_host_end.sv ***
// host end: frame generator, reset sequencer and receive buffer
`timescale 1ns/1ps
module adc_rx_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // depth must be a power of two for pointer wrap
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t r;
    fifo_t n;
    logic push;
    logic pop;

    assign in_ready_o = r.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = r.cnt != '0;
    assign out_data_o = r.mem[r.rp];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data_i;
            n.wp = r.wp + AW'(1);
        end
        if (pop) begin
            n.rp = r.rp + AW'(1);
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= n;
        end
    end
endmodule : adc_rx_fifo

module adc_host_end
    import adc_chain_pkg::*;
(
    // system
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // link
    adc_link_if.host LINK,
    // command words out
    input wire logic [31:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    input wire logic RESET_REQ_I,
    // result words in
    output logic [31:0] RX_DATA_O,
    output logic RX_VALID_O,
    input wire logic RX_READY_I
);
    typedef struct packed {
        host_state_t state;
        logic [15:0] timer;
        logic [15:0] bits;
        logic [31:0] tx_sr;
        logic [31:0] rx_sr;
        logic push;
        logic [31:0] push_data;
        logic cs;
        logic sclk;
        logic sdi;
        logic rstn;
        logic [2:0] rdy_s;
        logic [1:0] sdo_s;
    } host_t;

    localparam host_t HOST_INIT = '{
        state: H_RST,
        timer: RST_LOW_CYC,
        default: '0
    };

    host_t r;
    host_t n;
    logic fifo_ready;
    logic rdy_rise;
    logic timer_done;

    assign rdy_rise = r.rdy_s[1] & ~r.rdy_s[2];
    assign timer_done = r.timer <= 16'h0001;

    always_comb begin
        n = r;
        n.rdy_s = {r.rdy_s[1:0], LINK.ready_strobe};
        n.sdo_s = {r.sdo_s[0], LINK.sdo_line};
        n.push = 1'b0;
        if (!timer_done) begin
            n.timer = r.timer - 16'h0001;
        end
        case (r.state)
            H_RST: begin
                // select and clock stay low across the release
                if (timer_done) begin
                    n.rstn = 1'b1;
                    n.state = H_BOOT;
                end
            end
            H_BOOT: begin
                // first rise of select only runs a no-operation cycle
                if (r.rdy_s[1]) begin
                    n.cs = 1'b1;
                    n.timer = CONV_MAX_CYC;
                    n.state = H_WAIT;
                end
            end
            H_IDLE: begin
                if (RESET_REQ_I) begin
                    n.rstn = 1'b0;
                    n.cs = 1'b0;
                    n.timer = RST_LOW_CYC;
                    n.state = H_RST;
                end else if (TX_VALID_I) begin
                    n.cs = 1'b0;
                    n.tx_sr = TX_DATA_I;
                    n.sdi = TX_DATA_I[31];
                    n.bits = '0;
                    n.timer = SCLK_HALF_CYC;
                    n.state = H_FRAME;
                end
            end
            H_FRAME: begin
                if (timer_done && !r.sclk) begin
                    // clock pauses low before a word's last capture edge while the buffer has no room
                    if (r.bits[4:0] != WORD_LAST_BIT || fifo_ready) begin
                        n.sclk = 1'b1;
                        n.rx_sr = {r.rx_sr[30:0], r.sdo_s[1]};
                        n.bits = r.bits + 16'h0001;
                        n.timer = SCLK_HALF_CYC;
                        if (r.bits[4:0] == WORD_LAST_BIT) begin
                            n.push = 1'b1;
                            n.push_data = {r.rx_sr[30:0], r.sdo_s[1]};
                        end
                    end
                end else if (timer_done) begin
                    n.sclk = 1'b0;
                    n.timer = SCLK_HALF_CYC;
                    if (r.bits == FRAME_BITS) begin
                        n.state = H_CLOSE;
                    end else begin
                        // rotation repeats one word into every device
                        n.tx_sr = {r.tx_sr[30:0], r.tx_sr[31]};
                        n.sdi = r.tx_sr[30];
                    end
                end
            end
            H_CLOSE: begin
                if (timer_done) begin
                    n.cs = 1'b1;
                    n.timer = CONV_MAX_CYC;
                    n.state = H_WAIT;
                end
            end
            H_WAIT: begin
                if (rdy_rise || timer_done) begin
                    n.timer = ACQ_MIN_CYC;
                    n.state = H_ACQ;
                end
            end
            H_ACQ: begin
                if (timer_done) begin
                    n.state = H_IDLE;
                end
            end
            default: begin
                n.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= HOST_INIT;
        end else if (CE_I) begin
            r <= n;
        end
    end

    adc_rx_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .in_valid_i(r.push),
        .in_data_i(r.push_data),
        .in_ready_o(fifo_ready),
        .out_valid_o(RX_VALID_O),
        .out_data_o(RX_DATA_O),
        .out_ready_i(RX_READY_I)
    );

    assign TX_READY_O = (r.state == H_IDLE) & ~RESET_REQ_I;
    assign LINK.convert_start_select = r.cs;
    assign LINK.sclk = r.sclk;
    assign LINK.serial_in = r.sdi;
    assign LINK.reset_n = r.rstn;
endmodule : adc_host_end

// *** tb/adc_link_checker.sv ***
// concurrent checks on the link between the host end and the converter end
`timescale 1ns/1ps
module adc_link_checker (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // link
    input wire logic convert_start_select,
    input wire logic sclk,
    input wire logic reset_n,
    input wire logic sdo_oe_n,
    input wire logic ready_strobe,
    input wire logic sdo_line
);
    logic sel_q_r;
    logic sclk_q_r;
    logic in_frame_r;
    logic [6:0] rises_r;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    // a select fall under reset opens no frame, so its edge count is not checked
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            sel_q_r <= 1'b0;
            sclk_q_r <= 1'b0;
            in_frame_r <= 1'b0;
            rises_r <= 7'h00;
        end else begin
            sel_q_r <= convert_start_select;
            sclk_q_r <= sclk;
            if (!reset_n) in_frame_r <= 1'b0;
            else if (sel_q_r && !convert_start_select) in_frame_r <= 1'b1;
            else if (!sel_q_r && convert_start_select) in_frame_r <= 1'b0;
            if (sel_q_r && !convert_start_select) rises_r <= 7'h00;
            else if (sclk && !sclk_q_r && rises_r != 7'h7F) rises_r <= rises_r + 7'h01;
        end
    end

    sequence conv_busy;
        !ready_strobe [*8];
    endsequence
    sequence conv_end;
        ##[1:30] $rose(ready_strobe);
    endsequence

    ready_frame_a: assert property ($fell(convert_start_select) |-> ##[1:5] !ready_strobe)
        else $error("ready stayed high after frame start");
    sdo_drive_a: assert property ($fell(convert_start_select) && reset_n |->
        ##[1:5] (!sdo_oe_n || !reset_n))
        else $error("output not driven in frame");
    sdo_release_a: assert property ($rose(convert_start_select) |-> ##[1:5] sdo_oe_n)
        else $error("output not released at select rise");
    conv_busy_a: assert property ($rose(convert_start_select) |-> ##4 conv_busy)
        else $error("ready high during conversion");
    conv_done_a: assert property ($rose(convert_start_select) |-> conv_end)
        else $error("conversion did not end");
    reset_quiet_a: assert property ($fell(reset_n) |-> ##[1:5] (!ready_strobe && sdo_oe_n))
        else $error("reset left ready or output active");
    reset_exit_a: assert property ($rose(reset_n) |-> !convert_start_select && !sclk)
        else $error("reset raised with select or clock high");
    frame_len_a: assert property (!sel_q_r && convert_start_select && in_frame_r |->
        rises_r == 7'h20)
        else $error("frame without 32 capture edges");
    sdo_steady_a: assert property (sclk && $past(sclk) && !convert_start_select && reset_n |->
        $stable(sdo_line))
        else $error("output moved while clock high");
    acq_space_a: assert property ($rose(ready_strobe) && convert_start_select |->
        convert_start_select [*7])
        else $error("frame started inside acquisition time");
endmodule : adc_link_checker

// *** tb/tb_top.sv ***
// self-checking bench: host end against converter end, plus a bench-driven end
`timescale 1ns/1ps
module tb_top;
    import adc_chain_pkg::*;
    logic clk, rst, tx_valid, reset_req, rx_ready, func_sel, tx_ready, rx_valid;
    logic [31:0] tx_data, rx_data, cmd_word, cmd_word2;
    logic [15:0] code, result, last_code;
    logic cmd_valid, short_fr, app_rst, por, cmd_valid2, short2;
    logic [1:0] state, state2;
    int miscompares = 0;
    int comparisons = 0;

    adc_link_if link();
    adc_link_if link2();
    adc_host_end u_adc_host_end (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .LINK(link),
        .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
        .RESET_REQ_I(reset_req), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
        .RX_READY_I(rx_ready));
    adc_dev_end u_adc_dev_end (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .LINK(link),
        .ANALOG_CODE_I(code), .RESET_FUNC_SEL_I(func_sel), .CMD_WORD_O(cmd_word),
        .CMD_VALID_O(cmd_valid), .SHORT_FRAME_O(short_fr), .RESULT_O(result),
        .STATE_O(state), .APP_RESET_O(app_rst), .POR_O(por));
    // second end, its link driven by the bench to break the host's rules
    adc_dev_end u_adc_dev_end_b (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .LINK(link2),
        .ANALOG_CODE_I(code), .RESET_FUNC_SEL_I(func_sel), .CMD_WORD_O(cmd_word2),
        .CMD_VALID_O(cmd_valid2), .SHORT_FRAME_O(short2), .RESULT_O(),
        .STATE_O(state2), .APP_RESET_O(), .POR_O());
    adc_link_checker u_adc_link_checker (.CLOCK_I(clk), .RST_I(rst),
        .convert_start_select(link.convert_start_select), .sclk(link.sclk),
        .reset_n(link.reset_n), .sdo_oe_n(link.sdo_oe_n),
        .ready_strobe(link.ready_strobe), .sdo_line(link.sdo_line));

    always #25 clk = ~clk;

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    function automatic logic sig(input int k);
        case (k)
            0: return tx_ready;
            1: return cmd_valid;
            2: return cmd_valid2;
            3: return link.sclk;
            4: return link2.ready_strobe;
            5: return link.reset_n;
            default: return rx_valid;
        endcase
    endfunction : sig

    task automatic wait_for(input int k, input logic v, input int n);
        int i;
        for (i = 0; i < n && sig(k) !== v; i++) @(negedge clk);
        if (sig(k) !== v) begin
            miscompares++;
            $display("wrong value at %0t: wait %0d timed out", $time, k);
            stop_test();
        end
    endtask : wait_for

    task automatic t_boot();
        chk(por, 1'b1, "power-on flag in reset");
        chk(link.ready_strobe, 1'b0, "ready in reset");
        link2.convert_start_select = 1'b1;
        link2.reset_n = 1'b1;
        wait_for(0, 1'b1, 3000);
        chk(state, ST_ACQ, "state after boot");
        chk(link.ready_strobe, 1'b1, "ready after boot");
        chk(link2.ready_strobe, 1'b0, "left reset with select high");
        link2.convert_start_select = 1'b0;
        wait_for(4, 1'b1, 600);
        chk(state2, ST_ACQ, "chain end state after boot");
    endtask : t_boot

    task automatic t_frame(input logic [31:0] w, input logic [15:0] nc);
        logic [31:0] got;
        logic [31:0] sent;
        int i;
        code = nc;
        tx_data = w;
        tx_valid = 1'b1;
        wait_for(0, 1'b1, 100);
        @(negedge clk);
        tx_valid = 1'b0;
        for (i = 0; i < 32; i++) begin
            wait_for(3, 1'b1, 40);
            got = {got[30:0], link.sdo_line};
            sent = {sent[30:0], link.serial_in};
            wait_for(3, 1'b0, 40);
        end
        wait_for(1, 1'b1, 40);
        chk(got, {last_code, 16'h0000}, "word on the wire");
        chk(sent, w, "command on the wire");
        chk(cmd_word, w, "decoded word");
        chk(short_fr, 1'b0, "full frame flagged short");
        @(negedge clk);
        chk(state, ST_CONV, "state after select rise");
        chk(link.ready_strobe, 1'b0, "ready in conversion");
        wait_for(0, 1'b1, 100);
        chk(result, nc, "sampled code");
        wait_for(6, 1'b1, 10);
        chk(rx_data, {last_code, 16'h0000}, "received word");
        last_code = nc;
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask : t_frame

    // 33 frames against a full buffer: the last one must stall, not drop
    task automatic t_fill();
        int i;
        for (i = 0; i < 33; i++) begin
            @(negedge clk);
            code = 16'(i);
            tx_data = NOP_WORD;
            tx_valid = 1'b1;
            wait_for(0, 1'b1, 700);
            @(negedge clk);
            tx_valid = 1'b0;
        end
        repeat (700) @(negedge clk);
        chk(link.convert_start_select, 1'b0, "frame stalled on full buffer");
        chk(tx_ready, 1'b0, "host busy while stalled");
        rx_ready = 1'b1;
        for (i = 0; i < 33; i++) begin
            wait_for(6, 1'b1, 700);
            chk(rx_data, {(i == 0) ? last_code : 16'(i), 16'h0000}, "buffered word");
            @(negedge clk);
        end
        rx_ready = 1'b0;
        chk(rx_valid, 1'b0, "buffer empty");
        last_code = 16'h0020;
        wait_for(0, 1'b1, 100);
    endtask : t_fill

    task automatic t_reset(input logic sel);
        func_sel = sel;
        reset_req = 1'b1;
        wait_for(5, 1'b0, 40);
        reset_req = 1'b0;
        repeat (6) @(negedge clk);
        chk(app_rst, sel, "application reset flag");
        chk(por, !sel, "power-on reset flag");
        chk(state, ST_RESET, "state in reset");
        chk({link.ready_strobe, link.sdo_oe_n}, 2'h1, "ready and output in reset");
        chk(cmd_word, NOP_WORD, "configuration in reset");
        wait_for(0, 1'b1, 1000);
        chk(state, ST_ACQ, "state after reset");
        last_code = code;
    endtask : t_reset

    task automatic b_frame(input int nb, input logic [63:0] d, input logic sh);
        int i;
        link2.convert_start_select = 1'b1;
        repeat (4) @(negedge clk);
        wait_for(4, 1'b1, 60);
        link2.convert_start_select = 1'b0;
        repeat (6) @(negedge clk);
        for (i = nb - 1; i >= 0; i--) begin
            link2.serial_in = d[i];
            repeat (4) @(negedge clk);
            link2.sclk = 1'b1;
            repeat (4) @(negedge clk);
            link2.sclk = 1'b0;
        end
        link2.serial_in = ~d[0];
        repeat (6) @(negedge clk);
        link2.convert_start_select = 1'b1;
        wait_for(2, 1'b1, 20);
        chk(short2, sh, "short frame flag");
        chk(cmd_word2, sh ? NOP_WORD : d[31:0], "chain end word");
    endtask : b_frame

    // select pulsed inside a conversion must not start another
    task automatic t_ignore();
        int i;
        int seen;
        seen = 0;
        @(negedge clk);
        link2.convert_start_select = 1'b0;
        repeat (2) @(negedge clk);
        link2.convert_start_select = 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (cmd_valid2 === 1'b1) seen++;
        end
        chk(seen, 0, "select during conversion");
        chk(state2, ST_ACQ, "state after conversion");
    endtask : t_ignore

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        tx_valid = 1'b0;
        tx_data = NOP_WORD;
        reset_req = 1'b0;
        rx_ready = 1'b0;
        func_sel = 1'b0;
        code = 16'h1234;
        last_code = 16'h1234;
        link2.convert_start_select = 1'b0;
        link2.sclk = 1'b0;
        link2.serial_in = 1'b0;
        link2.reset_n = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_boot();
        t_frame(32'hA5C3_0F1E, 16'hFFFF);
        t_frame(32'h8000_0001, 16'h0000);
        t_fill();
        t_reset(1'b1);
        t_reset(1'b0);
        t_frame(32'h7FFF_FFFE, 16'h8001);
        b_frame(31, 64'h0000_0000_7FFF_FFFF, 1'b1);
        b_frame(40, 64'h0000_00A5_DEAD_BEEF, 1'b0);
        t_ignore();
        stop_test();
    end
endmodule : tb_top
